// >>> design/byte_fifo.sv
// transmit buffer memory, read data registered one cycle after pop
// assumes the owner never pushes when full nor pops when empty
`timescale 1ns/10ps
module byte_fifo
   import mode_ready_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = TX_BUF_BYTES
)(
   input wire logic sys_clk,
   input wire logic srst,
   fifo_if.store    port
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [LW-1:0]    cnt;
   logic             do_push;
   logic             do_pop;

   // guards keep a stray strobe from corrupting the pointers
   assign do_push    = port.push && (cnt != LW'(DEPTH));
   assign do_pop     = port.pop && (cnt != '0);
   assign port.level = cnt;

   // storage has no reset, only the pointers, fill count and read port do
   always_ff @(posedge sys_clk)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= port.wdata;
      end
   end

   // pointers and fill level
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt    <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         cnt <= cnt + LW'(do_push) - LW'(do_pop);
      end
   end

   // read port registered
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         port.rvalid <= 1'b0;
         port.rdata  <= '0;
      end
      else
      begin
         port.rvalid <= do_pop;
         if (do_pop)
         begin
            port.rdata <= mem[rd_ptr];
         end
      end
   end
endmodule

// >>> design/fifo_if.sv
// carrier between the control block and its transmit buffer memory
// assumes both ends run on sys_clk
`timescale 1ns/10ps
interface fifo_if #(
   parameter int WIDTH = 8,
   parameter int LW    = 10
);
   logic             push;
   logic [WIDTH-1:0] wdata;
   logic             pop;
   logic [WIDTH-1:0] rdata;
   logic             rvalid;
   logic [LW-1:0]    level;

   modport owner (output push, output wdata, output pop,
                  input rdata, input rvalid, input level);
   modport store (input push, input wdata, input pop,
                  output rdata, output rvalid, output level);
endinterface

// >>> design/mode_ready_pkg.sv
// shared constants for the mode select and ready indicator block
// assumes a single 125 MHz system clock and a synchronous reset
package mode_ready_pkg;

   // clock and timing, times in ns as specified
   localparam int CLK_PERIOD_NS = 8;
   localparam int SWITCH_NS     = 1_000_000; // longest mode-change delay
   localparam int HOLD_NS       = 2_000_000; // ready high before new mode
   localparam int SWITCH_CYC    = SWITCH_NS / CLK_PERIOD_NS;
   localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

   // buffering and framing
   localparam int TX_BUF_BYTES  = 1000;
   localparam int SUBPKT_BYTES  = 64;
   localparam int IDLE_CYC      = 32;  // host input end timeout
   localparam int CHECK_CYC     = 64;  // self-check length
   localparam int RELOAD_CYC    = 64;  // parameter reload length
   localparam int SKID_DEPTH    = 2;

   // fixed serial format while configuring
   localparam int CFG_BAUD      = 9600;
   localparam int CFG_DATA_BITS = 8;
   localparam int CFG_STOP_BITS = 1;

   localparam logic [15:0] ADDR_ALL = 16'hffff;

   // mode codes equal the pin pair {hi, lo}
   typedef enum logic [1:0] {
      MODE_TRANSMIT = 2'h0,
      MODE_WOR      = 2'h1,
      MODE_CONFIG   = 2'h2,
      MODE_SLEEP    = 2'h3
   } work_mode_e;

   typedef enum logic [2:0] {
      ST_CHECK  = 3'h1,
      ST_RELOAD = 3'h2,
      ST_RUN    = 3'h4
   } init_state_e;

endpackage

// >>> design/mode_select_ready_indicator.sv
// control of a serial-to-radio module: mode pins, ready indicator,
// 1000-byte transmit buffer drained to the radio chip in sub-packets
// assumes host uart logic and radio chip logic run on sys_clk; only
// the two mode pins are asynchronous
`timescale 1ns/10ps

module mode_select_ready_indicator
   import mode_ready_pkg::*;
#(
   parameter int CHECK_LEN  = CHECK_CYC,
   parameter int RELOAD_LEN = RELOAD_CYC,
   parameter int IDLE_LEN   = IDLE_CYC,
   parameter int SUBPKT     = SUBPKT_BYTES,
   parameter int HOLD_LEN   = HOLD_CYC,
   parameter int BUF_BYTES  = TX_BUF_BYTES
)(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        mode_select_hi,
   input  wire logic        mode_select_lo,
   input  wire logic [15:0] own_addr,
   input  wire logic        wor_role_tx,
   input  wire logic        host_valid,
   input  wire logic [7:0]  host_data,
   output logic             host_ready,
   output logic             radio_valid,
   output logic [7:0]       radio_data,
   output logic             radio_last,
   input  wire logic        radio_ready,
   input  wire logic        rx_frame_valid,
   input  wire logic [15:0] rx_frame_dest,
   output logic             rx_frame_accept,
   input  wire logic        uart_drained,
   output logic             ready_ind,
   output logic [1:0]       work_mode,
   output logic             mode_active,
   output logic             uart_en,
   output logic             radio_tx_en,
   output logic             radio_rx_en,
   output logic             wor_tx_en,
   output logic             wor_rx_en,
   output logic             cfg_access_en,
   output logic             cfg_fixed_9600,
   output logic             deep_sleep,
   output logic             tx_broadcast
);
   localparam int LW  = $clog2(BUF_BYTES + 1);
   localparam int LW1 = LW + 1;

   fifo_if #(.WIDTH(8), .LW(LW)) txq ();

   byte_fifo #(.WIDTH(8), .DEPTH(BUF_BYTES)) u_tx_buf (
      .sys_clk (sys_clk),
      .srst    (srst),
      .port    (txq.store)
   );

   logic [1:0]    mode_meta;
   logic [1:0]    mode_sync;
   init_state_e   state;
   logic [31:0]   init_cnt;
   logic          apply;
   logic          deferred;
   logic [31:0]   hold_cnt;
   logic          uart_pending;
   logic          tx_empty;
   logic          next_busy;
   logic          drain_mode;
   logic          run_ok;
   logic          accept;
   logic [LW:0]   next_level;
   logic [31:0]   idle_cnt;
   logic          draining;
   logic [31:0]   pkt_cnt;
   logic          issue_last;
   logic          rd_last;
   logic [8:0]    skid_q [SKID_DEPTH];
   logic [1:0]    skid_cnt;
   logic [1:0]    next_skid;
   logic          skid_in;
   logic          skid_out;
   logic          frame_ok;

   // frame address filter, all-ones own address listens to everyone
   function automatic logic addr_match(input logic [15:0] own,
                                       input logic [15:0] dest);
      addr_match = (own == ADDR_ALL) || (dest == own)
                   || (dest == ADDR_ALL);
   endfunction

   // mode pins are asynchronous, first stage read only by second
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mode_meta <= 2'h0;
         mode_sync <= 2'h0;
      end
      else
      begin
         mode_meta <= {mode_select_hi, mode_select_lo};
         mode_sync <= mode_meta;
      end
   end

   // start-up sequence: self-check, reload, then run; sleep exit
   // goes back through reload
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state    <= ST_CHECK;
         init_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_CHECK:
            begin
               if (init_cnt == 32'(CHECK_LEN - 1))
               begin
                  state    <= ST_RELOAD;
                  init_cnt <= '0;
               end
               else
               begin
                  init_cnt <= init_cnt + 32'h1;
               end
            end
            ST_RELOAD:
            begin
               if (init_cnt == 32'(RELOAD_LEN - 1))
               begin
                  state    <= ST_RUN;
                  init_cnt <= '0;
               end
               else
               begin
                  init_cnt <= init_cnt + 32'h1;
               end
            end
            ST_RUN:
            begin
               if (apply && work_mode == MODE_SLEEP)
               begin
                  state    <= ST_RELOAD;
                  init_cnt <= '0;
               end
            end
            default:
            begin
               state    <= ST_CHECK;
               init_cnt <= '0;
            end
         endcase
      end
   end

   // busy terms; the buffer counts empty once its last byte has gone
   // to the radio chip, even if that sub-packet is still on air
   assign tx_empty  = (txq.level == '0) && !txq.rvalid
                      && (skid_cnt == 2'h0);
   assign next_busy = (state != ST_RUN) || uart_pending
                      || !tx_empty;

   // indicator register, low out of reset
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ready_ind <= 1'b0;
      end
      else
      begin
         ready_ind <= !next_busy;
      end
   end

   // pins only applied while idle, so a change during activity
   // waits for the work in the old mode to finish
   assign apply = ready_ind && (mode_sync != work_mode);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         work_mode <= MODE_TRANSMIT;
         deferred  <= 1'b0;
      end
      else
      begin
         if (apply)
         begin
            work_mode <= mode_sync;
            deferred  <= 1'b0;
         end
         else if (!ready_ind && state == ST_RUN
                  && mode_sync != work_mode)
         begin
            deferred <= 1'b1;
         end
      end
   end

   // a deferred switch holds mode_active low until the indicator has
   // stayed high for the full hold time; a drop restarts the wait
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         hold_cnt    <= '0;
         mode_active <= 1'b0;
      end
      else
      begin
         if (apply && deferred)
         begin
            hold_cnt <= 32'(HOLD_LEN);
         end
         else if (hold_cnt != '0)
         begin
            hold_cnt <= ready_ind ? hold_cnt - 32'h1 : 32'(HOLD_LEN);
         end
         mode_active <= (hold_cnt == '0) && !(apply && deferred);
      end
   end

   assign run_ok     = (state == ST_RUN) && mode_active;
   assign drain_mode = (state == ST_RUN) && (work_mode == MODE_TRANSMIT
                       || work_mode == MODE_WOR);

   // mode decode onto function enables
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         uart_en        <= 1'b0;
         radio_tx_en    <= 1'b0;
         radio_rx_en    <= 1'b0;
         wor_tx_en      <= 1'b0;
         wor_rx_en      <= 1'b0;
         cfg_access_en  <= 1'b0;
         cfg_fixed_9600 <= 1'b0;
         deep_sleep     <= 1'b0;
         tx_broadcast   <= 1'b0;
      end
      else
      begin
         uart_en        <= run_ok && work_mode != MODE_SLEEP;
         radio_tx_en    <= drain_mode && (work_mode == MODE_TRANSMIT
                           || wor_role_tx);
         radio_rx_en    <= run_ok && (work_mode == MODE_TRANSMIT
                           || (work_mode == MODE_WOR
                               && !wor_role_tx));
         wor_tx_en      <= run_ok && work_mode == MODE_WOR
                           && wor_role_tx;
         wor_rx_en      <= run_ok && work_mode == MODE_WOR
                           && !wor_role_tx;
         cfg_access_en  <= run_ok && work_mode == MODE_CONFIG;
         cfg_fixed_9600 <= work_mode == MODE_CONFIG;
         deep_sleep     <= work_mode == MODE_SLEEP;
         tx_broadcast   <= own_addr == ADDR_ALL
                           && work_mode == MODE_TRANSMIT;
      end
   end

   // received frames; pending uart output set wins over drained
   assign frame_ok = rx_frame_valid && radio_rx_en
                     && addr_match(own_addr, rx_frame_dest);
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rx_frame_accept <= 1'b0;
         uart_pending    <= 1'b0;
      end
      else
      begin
         rx_frame_accept <= frame_ok;
         if (frame_ok)
         begin
            uart_pending <= 1'b1;
         end
         else if (uart_drained)
         begin
            uart_pending <= 1'b0;
         end
      end
   end

   // host side of the buffer; ready looks one push ahead so the
   // registered flag can never admit a byte past the last slot
   assign accept     = host_valid && host_ready;
   assign txq.push   = accept;
   assign txq.wdata  = host_data;
   assign next_level = LW1'(txq.level) + LW1'(txq.push)
                       - LW1'(txq.pop);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         host_ready <= 1'b0;
      end
      else
      begin
         host_ready <= run_ok && drain_mode
                       && (next_level < LW1'(BUF_BYTES));
      end
   end

   // input end detection: drain starts after an idle gap or when full
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         idle_cnt <= '0;
         draining <= 1'b0;
      end
      else
      begin
         if (accept)
         begin
            idle_cnt <= '0;
         end
         else if (idle_cnt != 32'(IDLE_LEN))
         begin
            idle_cnt <= idle_cnt + 32'h1;
         end
         if (txq.level == '0)
         begin
            draining <= 1'b0;
         end
         else if (drain_mode && (idle_cnt == 32'(IDLE_LEN)
                  || txq.level == LW'(BUF_BYTES)))
         begin
            draining <= 1'b1;
         end
      end
   end

   // pop only when the skid buffer has room for the word in flight;
   // this costs throughput but keeps the two-entry buffer simple
   assign txq.pop    = draining && (txq.level != '0)
                       && (skid_cnt == 2'h0
                           || (skid_cnt == 2'h1 && !txq.rvalid));
   assign issue_last = (txq.level == LW'(1))
                       || (pkt_cnt == 32'(SUBPKT - 1));

   // sub-packet byte count and end marker of each sub-packet
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pkt_cnt <= '0;
         rd_last <= 1'b0;
      end
      else if (txq.pop)
      begin
         pkt_cnt <= issue_last ? '0 : pkt_cnt + 32'h1;
         rd_last <= issue_last;
      end
   end

   // two-entry buffer toward the radio chip
   assign skid_in   = txq.rvalid;
   assign skid_out  = radio_valid && radio_ready;
   assign next_skid = skid_cnt + 2'(skid_in) - 2'(skid_out);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         skid_cnt    <= 2'h0;
         radio_valid <= 1'b0;
         skid_q[0]   <= '0;
         skid_q[1]   <= '0;
      end
      else
      begin
         skid_cnt    <= next_skid;
         radio_valid <= next_skid != 2'h0;
         if (skid_in && !skid_out)
         begin
            skid_q[skid_cnt[0]] <= {rd_last, txq.rdata};
         end
         else if (skid_out)
         begin
            skid_q[0] <= (skid_cnt == 2'h1) ? {rd_last, txq.rdata}
                                            : skid_q[1];
            skid_q[1] <= {rd_last, txq.rdata};
         end
      end
   end

   assign radio_data = skid_q[0][7:0];
   assign radio_last = skid_q[0][8];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_start_low: assert property (state != ST_RUN |=> !ready_ind)
      else $error("indicator high during start-up");
   a_uart_busy: assert property (uart_pending |=> !ready_ind)
      else $error("indicator high with uart output pending");
   a_buf_busy: assert property (txq.level != '0 |=> !ready_ind)
      else $error("indicator high with buffered bytes");
   a_pins_ignored: assert property (!ready_ind |=> $stable(work_mode))
      else $error("mode changed while busy");
   a_mode_applied: assert property (ready_ind && mode_sync != work_mode
      |=> work_mode == $past(mode_sync))
      else $error("pending mode not applied");
   a_hold_wait: assert property (apply && deferred
      |=> !mode_active [*2])
      else $error("deferred mode active too early");
   a_switch_now: assert property (apply && !deferred && hold_cnt == '0
      |=> mode_active)
      else $error("immediate switch delayed");
   a_sleep_reload: assert property (apply && work_mode == MODE_SLEEP
      |=> state == ST_RELOAD ##1 !ready_ind)
      else $error("no reload on sleep exit");
   a_no_overflow: assert property (host_ready
      |-> txq.level < LW'(BUF_BYTES))
      else $error("host admitted into full buffer");
   a_idle_drain: assert property (idle_cnt == 32'(IDLE_LEN)
      && txq.level != '0 && drain_mode |=> draining)
      else $error("drain did not start after idle");
   a_listen_all: assert property (rx_frame_valid && radio_rx_en
      && own_addr == ADDR_ALL |=> rx_frame_accept)
      else $error("listen address dropped a frame");
   a_sleep_quiet: assert property (deep_sleep
      |-> !radio_tx_en && !radio_rx_en)
      else $error("radio active in sleep");
endmodule

// >>> sim/host_model.sv
// host side model: offers bytes one at a time and watches the indicator
// assumes it shares sys_clk with the block and is driven by task calls
`timescale 1ns/10ps
module host_model (
   input  wire logic       sys_clk,
   input  wire logic       host_ready,
   input  wire logic       ready_ind,
   output logic            host_valid,
   output logic [7:0]      host_data
);
   initial
   begin
      host_valid = 1'b0;
      host_data  = 8'h00;
   end

   // byte held until taken; gives up after 64 cycles of refusal
   task automatic send(input logic [7:0] b, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      host_valid <= 1'b1;
      host_data  <= b;
      while (!ok && n < 64)
      begin
         @(posedge sys_clk);
         ok = (host_ready === 1'b1);
         n++;
      end
   endtask

   // released data shows the inverse so a stale byte cannot pass
   task automatic release_bus();
      host_valid <= 1'b0;
      host_data  <= ~host_data;
   endtask

   // first rise of the indicator is the point of normal use
   task automatic wait_ready(output logic ok);
      int n;
      n = 0;
      while (ready_ind !== 1'b1 && n < 100)
      begin
         @(posedge sys_clk);
         n++;
      end
      ok = (ready_ind === 1'b1);
   endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the mode select and ready indicator block
// assumes host_model beside it; short start-up and hold counts for speed
`timescale 1ns/10ps
module testbench
   import mode_ready_pkg::*;
;
   localparam int SUB  = 4;
   localparam int HOLD = 20;
   logic        sys_clk, srst, mode_select_hi, mode_select_lo, wor_role_tx;
   logic        host_valid, host_ready, radio_valid, radio_last, radio_ready;
   logic        rx_frame_valid, rx_frame_accept, uart_drained, ready_ind;
   logic        mode_active, uart_en, radio_tx_en, radio_rx_en, wor_tx_en;
   logic        wor_rx_en, cfg_access_en, cfg_fixed_9600, deep_sleep;
   logic        tx_broadcast, hold_radio, ok;
   logic [1:0]  work_mode, m;
   logic [7:0]  host_data, radio_data, b;
   logic [15:0] own_addr, rx_frame_dest, seed, rnd;
   logic [15:0] own_t [4] = '{16'h1234, 16'h1234, 16'hffff, 16'h1234};
   logic [15:0] dst_t [4] = '{16'h1234, 16'h1235, 16'h0042, 16'hffff};
   logic [3:0]  acc_t = 4'b1011;
   logic [8:0]  q[$];
   int          miscompares, comparisons, cycles, n;

   mode_select_ready_indicator #(.CHECK_LEN(4), .RELOAD_LEN(4),
      .IDLE_LEN(4), .SUBPKT(SUB), .HOLD_LEN(HOLD))
   mode_select_ready_indicator_i (.sys_clk(sys_clk), .srst(srst),
      .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
      .own_addr(own_addr), .wor_role_tx(wor_role_tx),
      .host_valid(host_valid), .host_data(host_data),
      .host_ready(host_ready), .radio_valid(radio_valid),
      .radio_data(radio_data), .radio_last(radio_last),
      .radio_ready(radio_ready), .rx_frame_valid(rx_frame_valid),
      .rx_frame_dest(rx_frame_dest), .rx_frame_accept(rx_frame_accept),
      .uart_drained(uart_drained), .ready_ind(ready_ind),
      .work_mode(work_mode), .mode_active(mode_active), .uart_en(uart_en),
      .radio_tx_en(radio_tx_en), .radio_rx_en(radio_rx_en),
      .wor_tx_en(wor_tx_en), .wor_rx_en(wor_rx_en),
      .cfg_access_en(cfg_access_en), .cfg_fixed_9600(cfg_fixed_9600),
      .deep_sleep(deep_sleep), .tx_broadcast(tx_broadcast));

   host_model host_model_i (.sys_clk(sys_clk), .host_ready(host_ready),
      .ready_ind(ready_ind), .host_valid(host_valid), .host_data(host_data));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t status %h expected %h", $time, got, exp);
      end
   endtask

   // an empty queue yields the inverse so a stray byte always fails
   task automatic chk_byte(input logic [8:0] got);
      logic [8:0] exp;
      exp = (q.size() > 0) ? q.pop_front() : ~got;
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ind(input logic v, input int lim);
      int k;
      k = 0;
      while (ready_ind !== v && k < lim)
      begin
         @(posedge sys_clk);
         k++;
      end
   endtask

   task automatic set_mode(input logic [1:0] v);
      mode_select_hi <= v[1];
      mode_select_lo <= v[0];
   endtask

   // radio chip side: stalls at random, or fully while hold_radio
   always @(posedge sys_clk)
   begin
      rnd <= lfsr(rnd);
      radio_ready <= hold_radio ? 1'b0 : rnd[0];
      if (radio_valid === 1'b1 && radio_ready === 1'b1)
         chk_byte({radio_last, radio_data});
   end

   // hang guard well above the longest drain
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         summarize();
      end
   end

   initial
   begin
      {srst, mode_select_hi, mode_select_lo, wor_role_tx} = 4'b1001;
      {rx_frame_valid, uart_drained, hold_radio, radio_ready} = 4'h0;
      own_addr = 16'h1234;
      rx_frame_dest = 16'h0000;
      seed = 16'd38976;
      rnd = 16'd38976;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(ready_ind, 0);
      host_model_i.wait_ready(ok);
      chk(ok, 1);
      // every code; leaving sleep reloads with the indicator low
      for (int i = 1; i < 5; i++)
      begin
         m = i[1:0];
         set_mode(m);
         repeat (6) @(posedge sys_clk);
         if (m == 2'h0)
         begin
            chk(ready_ind, 0);
            wait_ind(1'b1, 100);
            repeat (HOLD + 8) @(posedge sys_clk);
         end
         chk(work_mode, m);
         chk({mode_active, deep_sleep, cfg_access_en, cfg_fixed_9600,
              uart_en}, {1'b1, m == 3, m == 2, m == 2,
              m != 3});
         // both wake roles looked at in every mode, role restored after
         repeat (2)
         begin
            chk({wor_tx_en, wor_rx_en, radio_rx_en, radio_tx_en},
                {m == 1 && wor_role_tx, m == 1 && !wor_role_tx,
                 m == 0 || (m == 1 && !wor_role_tx),
                 m == 0 || (m == 1 && wor_role_tx)});
            wor_role_tx <= ~wor_role_tx;
            repeat (2) @(posedge sys_clk);
         end
      end
      // address filter; an accepted frame holds the indicator low
      for (int i = 0; i < 4; i++)
      begin
         own_addr <= own_t[i];
         rx_frame_dest <= dst_t[i];
         rx_frame_valid <= 1'b1;
         @(posedge sys_clk);
         rx_frame_valid <= 1'b0;
         @(posedge sys_clk);
         chk(rx_frame_accept, acc_t[3 - i]);
         repeat (3) @(posedge sys_clk);
         chk(ready_ind, !acc_t[3 - i]);
         uart_drained <= 1'b1;
         @(posedge sys_clk);
         uart_drained <= 1'b0;
         wait_ind(1'b1, 10);
         chk(ready_ind, 1);
      end
      own_addr <= 16'hffff;
      repeat (4) @(posedge sys_clk);
      chk(tx_broadcast, 1);
      own_addr <= 16'h1234;
      // burst held back; a mode change meanwhile is deferred
      hold_radio <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         seed = lfsr(seed);
         q.push_back({i % SUB == SUB - 1 || i == 9, seed[7:0]});
         host_model_i.send(seed[7:0], ok);
      end
      host_model_i.release_bus();
      repeat (12) @(posedge sys_clk);
      chk({ready_ind, tx_broadcast}, 0);
      set_mode(2'h2);
      repeat (8) @(posedge sys_clk);
      chk(work_mode, 0);
      hold_radio <= 1'b0;
      wait_ind(1'b1, 300);
      @(posedge sys_clk);
      chk(q.size(), 0);
      repeat (4) @(posedge sys_clk);
      chk({work_mode, mode_active}, {2'h2, 1'b0});
      repeat (HOLD + 4) @(posedge sys_clk);
      chk(mode_active, 1);
      set_mode(2'h0);
      repeat (8) @(posedge sys_clk);
      // fill until refused, then drain against a stalling radio chip
      hold_radio <= 1'b1;
      n = 0;
      ok = 1'b1;
      while (ok && n < 1100)
      begin
         seed = lfsr(seed);
         b = seed[7:0];
         host_model_i.send(b, ok);
         if (ok)
         begin
            q.push_back({n % SUB == SUB - 1, b});
            n++;
         end
      end
      q[q.size() - 1][8] = 1'b1;
      chk(host_ready, 0);
      chk(n >= TX_BUF_BYTES && n <= TX_BUF_BYTES + 2, 1);
      host_model_i.release_bus();
      hold_radio <= 1'b0;
      repeat (20) @(posedge sys_clk);
      wait_ind(1'b1, 20000);
      @(posedge sys_clk);
      chk(q.size(), 0);
      summarize();
   end
endmodule
